/* core/sq_sequencer.sv */
// Point-to-point step sequencer with AHB-Lite register slave.
// Assumes external inputs asynchronous; motion_ref_in and move_done on hclk.
// How it works
// - each step waits its own dwell count
// - each step applies its own smoothing time
// - selection 0/2 cyclic, 1/3 single run
// - selection 2/3 swaps start and search inputs
// - reference search always forward direction
// - mode 0: delay advance, start after servo-on
// - mode 1: input advance, start after servo-on
// - mode 2: delay advance, start input required
// - mode 3: input advance, start input required
// - modes 2/3: start release halts pulses
// - reset returns pointer to start step
// - step input detected by level or pulse
`timescale 1ns/10ps
module sq_sequencer import sq_pkg::*; #(
   parameter int unsigned TICK_CYCLES = SQ_TICK_CYCLES
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        servo_on,
   input  wire logic        positive_side_input,
   input  wire logic        negative_side_input,
   input  wire logic        step_change_input,
   input  wire logic        move_done,
   input  wire logic [15:0] motion_ref_in,
   output logic [15:0]      motion_ref_out,
   output logic             pulse_enable,
   output logic [3:0]       current_step,
   output logic             program_done,
   output logic             homing_start,
   output logic             homing_dir_fwd
);
   logic [15:0] filt_time [SQ_STEPS];
   logic [15:0] dwell_time [SQ_STEPS];
   logic [15:0] program_run_config;
   logic [3:0]  start_step;
   logic [3:0]  stop_step;
   logic        wr_pend;
   logic [11:0] wr_addr;
   logic        soft_rst;
   sq_state_t   st;
   sq_state_t   next_st;
   logic [3:0]  next_step;
   logic        fresh;
   logic [15:0] dwell_cnt;
   logic [15:0] delay_cnt;
   logic [3:0]  sync1;
   logic [3:0]  sync2;
   logic [3:0]  sync3;
   logic        tick;
   logic [1:0]  run_and_start_selection;
   logic [1:0]  step_advance_mode;
   logic        step_input_detect_mode;
   logic        servo_s;
   logic        start_s;
   logic        search_s;
   logic        search_q;
   logic        step_evt;
   logic        halt;
   logic        adv;
   logic        cyclic;

   sq_filt_if fif ();

   sq_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick    (tick)
   );

   sq_filter u_filter (
      .hclk    (hclk),
      .hresetn (hresetn),
      .fi      (fif.flt)
   );

   function automatic logic [3:0] sat_shift(input logic [15:0] t);
      sat_shift = (t > 16'h000F) ? 4'hF : t[3:0];
   endfunction

   function automatic logic [31:0] rd_mux(input logic [11:0] a);
      rd_mux = 32'h0000_0000;
      if (a >= SQ_OFS_FILT && a < SQ_OFS_DWELL)
         rd_mux = {16'h0000, filt_time[a[5:2]]};
      else if (a >= SQ_OFS_DWELL && a < SQ_OFS_RSVD)
         rd_mux = {16'h0000, dwell_time[a[5:2]]};
      else if (a == SQ_OFS_CFG)
         rd_mux = {16'h0000, program_run_config};
      else if (a == SQ_OFS_STEPS)
         rd_mux = {20'h0_0000, stop_step, 4'h0, start_step};
      else if (a == SQ_OFS_STATUS)
         rd_mux = {14'h0000, program_done, pulse_enable, 2'h0, st, 4'h0, current_step};
   endfunction

   // Bus slave: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign soft_rst  = wr_pend && wr_addr == SQ_OFS_CTRL && hwdata[SQ_CTRL_SRST_BIT];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 12'h000;
         hrdata  <= 32'h0000_0000;
      end else if (hready) begin
         wr_pend <= hsel && htrans[1] && hwrite;
         wr_addr <= {haddr[11:2], 2'b00};
         if (hsel && htrans[1] && !hwrite)
            hrdata <= rd_mux({haddr[11:2], 2'b00});
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < SQ_STEPS; i++) begin
            filt_time[i]  <= SQ_RST_FILT;
            dwell_time[i] <= SQ_RST_DWELL;
         end
         program_run_config <= SQ_RST_CFG;
         start_step         <= SQ_RST_START_STEP;
         stop_step          <= SQ_RST_STOP_STEP;
      end else if (wr_pend) begin
         if (wr_addr >= SQ_OFS_FILT && wr_addr < SQ_OFS_DWELL)
            filt_time[wr_addr[5:2]] <= hwdata[15:0];
         else if (wr_addr >= SQ_OFS_DWELL && wr_addr < SQ_OFS_RSVD)
            dwell_time[wr_addr[5:2]] <= hwdata[15:0];
         else if (wr_addr == SQ_OFS_CFG)
            program_run_config <= hwdata[15:0];
         else if (wr_addr == SQ_OFS_STEPS) begin
            start_step <= hwdata[3:0];
            stop_step  <= hwdata[SQ_STEPS_STOP_LSB +: 4];
         end
      end
   end

   assign run_and_start_selection = program_run_config[SQ_CFG_SEL_LSB +: 2];
   assign step_advance_mode       = program_run_config[SQ_CFG_MODE_LSB +: 2];
   assign step_input_detect_mode  = program_run_config[SQ_CFG_DET_LSB];

   // Pins: two flops, third stage only for edge detection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         sync3 <= 4'h0;
      end else begin
         sync1 <= {servo_on, positive_side_input, negative_side_input, step_change_input};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   assign servo_s  = sync2[3];
   assign start_s  = run_and_start_selection[1] ? sync2[1] : sync2[2];
   assign search_s = run_and_start_selection[1] ? sync2[2] : sync2[1];
   assign search_q = run_and_start_selection[1] ? sync3[2] : sync3[1];
   assign step_evt = step_input_detect_mode ? (sync2[0] && !sync3[0]) : sync2[0];
   assign cyclic   = !run_and_start_selection[0];
   // Modes 2/3 drop at once when start is released
   assign halt     = !servo_s || (step_advance_mode[1] && !start_s);

   // Homing search is requested on a rising edge, always forward
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         homing_start <= 1'b0;
      end else begin
         homing_start <= search_s && !search_q;
      end
   end
   assign homing_dir_fwd = 1'b1;

   always_comb begin
      next_st   = st;
      next_step = current_step;
      adv       = 1'b0;
      case (st)
         SQ_IDLE: begin
            if (servo_s && step_advance_mode[1] && start_s)
               next_st = SQ_MOVE;
            else if (servo_s && !step_advance_mode[1])
               next_st = SQ_DELAY;
            if (next_st != SQ_IDLE && fresh)
               next_step = start_step;
         end
         SQ_DELAY: begin
            if (tick && delay_cnt + 16'h0001 >= SQ_START_DELAY_TK)
               next_st = SQ_MOVE;
         end
         SQ_MOVE: begin
            if (move_done)
               next_st = SQ_DWELL;
         end
         SQ_DWELL: begin
            if (dwell_cnt == 16'h0000) begin
               if (step_advance_mode[0])
                  next_st = SQ_WAIT_STEP;
               else
                  adv = 1'b1;
            end
         end
         SQ_WAIT_STEP: begin
            adv = step_evt;
         end
         SQ_DONE: begin
         end
         default: begin
            next_st = SQ_IDLE;
         end
      endcase
      if (adv) begin
         if (current_step == stop_step) begin
            next_st   = cyclic ? SQ_MOVE : SQ_DONE;
            next_step = start_step;
         end else begin
            next_st   = SQ_MOVE;
            next_step = current_step + 4'h1;
         end
      end
      if (halt && st != SQ_DONE)
         next_st = SQ_IDLE;
      if (!servo_s)
         next_st = SQ_IDLE;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st           <= SQ_IDLE;
         current_step <= SQ_RST_START_STEP;
         fresh        <= 1'b1;
      end else if (soft_rst) begin
         st           <= SQ_IDLE;
         current_step <= start_step;
         fresh        <= 1'b1;
      end else begin
         st           <= next_st;
         current_step <= next_step;
         if (st == SQ_IDLE && next_st != SQ_IDLE)
            fresh <= 1'b0;
         else if (!servo_s || next_st == SQ_DONE)
            fresh <= 1'b1;
      end
   end

   // Dwell loaded after the move, one unit per tick
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dwell_cnt <= 16'h0000;
      end else if (st == SQ_MOVE && move_done) begin
         dwell_cnt <= dwell_time[current_step];
      end else if (st == SQ_DWELL && tick && dwell_cnt != 16'h0000) begin
         dwell_cnt <= dwell_cnt - 16'h0001;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         delay_cnt <= 16'h0000;
      end else if (st != SQ_DELAY) begin
         delay_cnt <= 16'h0000;
      end else if (tick) begin
         delay_cnt <= delay_cnt + 16'h0001;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pulse_enable <= 1'b0;
         program_done <= 1'b0;
      end else begin
         pulse_enable <= next_st == SQ_MOVE && !soft_rst;
         program_done <= next_st == SQ_DONE && !soft_rst;
      end
   end

   assign fif.target    = pulse_enable ? motion_ref_in : 16'h0000;
   assign fif.shift     = sat_shift(filt_time[current_step]);
   assign motion_ref_out = fif.smoothed;

   halt_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (step_advance_mode[1] && !start_s && st != SQ_DONE && !soft_rst) |=> !pulse_enable)
      else $error("pulses not halted on start release");
   dwell_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (st == SQ_DWELL && dwell_cnt != 16'h0000 && !halt && !soft_rst) |=> st == SQ_DWELL)
      else $error("dwell left early");
   dwell_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (st == SQ_MOVE && move_done) |=> dwell_cnt == $past(dwell_time[current_step]))
      else $error("dwell not loaded from step");
   tick_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (st == SQ_DWELL && !tick) |=> $stable(dwell_cnt))
      else $error("dwell changed without tick");
   cyclic_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (adv && current_step == stop_step && cyclic && !halt && servo_s && !soft_rst)
      |=> (st == SQ_MOVE && current_step == $past(start_step)))
      else $error("cyclic wrap failed");
   single_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (adv && current_step == stop_step && !cyclic && !halt && servo_s && !soft_rst)
      |=> program_done)
      else $error("single run did not stop");
   step_incr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (adv && current_step != stop_step && !soft_rst) |=> current_step == $past(current_step) + 4'h1)
      else $error("step not incremented");
   home_fwd_a: assert property (@(posedge hclk) disable iff (!hresetn)
      homing_start |-> homing_dir_fwd)
      else $error("homing not forward");
   home_trig_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (search_s && !search_q) |=> homing_start)
      else $error("search edge missed");
   wait_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (st == SQ_WAIT_STEP && !step_evt && servo_s && !halt && !soft_rst) |=> st == SQ_WAIT_STEP)
      else $error("advanced without step input");
   soft_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
      soft_rst |=> (current_step == $past(start_step) && st == SQ_IDLE))
      else $error("reset did not return to start");
   filt_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (filt_time[current_step] == 16'h0000) |=> motion_ref_out == $past(fif.target))
      else $error("unfiltered step did not pass reference");

   run_cyclic_c: cover property (@(posedge hclk) disable iff (!hresetn)
      adv && current_step == stop_step && cyclic);
   run_single_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(program_done));
   step_input_c: cover property (@(posedge hclk) disable iff (!hresetn) st == SQ_WAIT_STEP && step_evt);
   start_halt_c: cover property (@(posedge hclk) disable iff (!hresetn)
      st == SQ_MOVE && step_advance_mode[1] && !start_s);
endmodule

/* core/sq_pkg.sv */
// Package for the point-to-point step sequencer: register map, fields, timing.
// Assumes a 40 MHz hclk and a 32-bit AHB-Lite register bus.
package sq_pkg;
   localparam int          SQ_STEPS           = 16;
   localparam int          SQ_CLK_HZ          = 40_000_000;
   localparam int          SQ_TICK_MS         = 50;
   localparam int          SQ_TICK_CYCLES     = SQ_CLK_HZ / 1000 * SQ_TICK_MS;
   localparam logic [15:0] SQ_START_DELAY_TK  = 16'h0001;
   // Byte offsets
   localparam logic [11:0] SQ_OFS_FILT        = 12'h000;
   localparam logic [11:0] SQ_OFS_DWELL       = 12'h040;
   localparam logic [11:0] SQ_OFS_RSVD        = 12'h080;
   localparam logic [11:0] SQ_OFS_CFG         = 12'h084;
   localparam logic [11:0] SQ_OFS_STEPS       = 12'h088;
   localparam logic [11:0] SQ_OFS_CTRL        = 12'h08C;
   localparam logic [11:0] SQ_OFS_STATUS      = 12'h090;
   // Field positions
   localparam int          SQ_CFG_SEL_LSB     = 0;
   localparam int          SQ_CFG_MODE_LSB    = 4;
   localparam int          SQ_CFG_DET_LSB     = 8;
   localparam int          SQ_STEPS_STOP_LSB  = 8;
   localparam int          SQ_CTRL_SRST_BIT   = 0;
   // Reset values
   localparam logic [15:0] SQ_RST_FILT        = 16'h0000;
   localparam logic [15:0] SQ_RST_DWELL       = 16'h0000;
   localparam logic [15:0] SQ_RST_CFG         = 16'h0000;
   localparam logic [3:0]  SQ_RST_START_STEP  = 4'h0;
   localparam logic [3:0]  SQ_RST_STOP_STEP   = 4'hF;

   typedef enum logic [5:0] {
      SQ_IDLE      = 6'h01,
      SQ_DELAY     = 6'h02,
      SQ_MOVE      = 6'h04,
      SQ_DWELL     = 6'h08,
      SQ_WAIT_STEP = 6'h10,
      SQ_DONE      = 6'h20
   } sq_state_t;
endpackage

/* core/sq_filt_if.sv */
// Interface between sequencer control and its reference smoothing filter.
// Assumes both ends run on the same hclk.
`timescale 1ns/10ps
interface sq_filt_if;
   logic signed [15:0] target;
   logic        [3:0]  shift;
   logic signed [15:0] smoothed;
   modport ctl (output target, output shift, input smoothed);
   modport flt (input target, input shift, output smoothed);
endinterface

/* core/sq_tick.sv */
// Timebase divider: one-cycle tick every TICK_CYCLES clocks.
// Assumes a free-running hclk.
`timescale 1ns/10ps
module sq_tick #(
   parameter int unsigned TICK_CYCLES = 2
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   output logic      tick
);
   logic [31:0] cnt;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt  <= 32'h0000_0000;
         tick <= 1'b0;
      end else if (cnt >= 32'(TICK_CYCLES - 1)) begin
         cnt  <= 32'h0000_0000;
         tick <= 1'b1;
      end else begin
         cnt  <= cnt + 32'h0000_0001;
         tick <= 1'b0;
      end
   end
endmodule

/* core/sq_filter.sv */
// First-order smoothing of the motion reference, time constant 2**shift clocks.
// Assumes target from the same clock domain.
`timescale 1ns/10ps
module sq_filter (
   input  wire logic hclk,
   input  wire logic hresetn,
   sq_filt_if.flt    fi
);
   logic signed [16:0] diff;

   assign diff = 17'(fi.target) - 17'(fi.smoothed);

   // Truncating shift leaves a residual below 2**shift; kept for area
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fi.smoothed <= 16'sh0000;
      end else begin
         fi.smoothed <= 16'(17'(fi.smoothed) + (diff >>> fi.shift));
      end
   end
endmodule

/* dv/sq_partner.sv */
// Far-side model: start and search switches, step-change input, move completion.
// Assumes bench commands change just after rising hclk edges; pins are plain levels.
`timescale 1ns/10ps
module sq_partner (
   input  wire logic       hclk,
   input  wire logic       swap,
   input  wire logic       start_cmd,
   input  wire logic       search_cmd,
   input  wire logic       step_cmd,
   input  wire logic       pulse_enable,
   input  wire logic [7:0] move_len,
   output logic            positive_side_input,
   output logic            negative_side_input,
   output logic            step_change_input,
   output logic            move_done
);
   logic [7:0] cnt;
   // Switch wiring follows the selection the bench programmed
   assign positive_side_input = swap ? search_cmd : start_cmd;
   assign negative_side_input = swap ? start_cmd : search_cmd;
   assign step_change_input   = step_cmd;
   // Long move_len keeps a move running, so halts can be seen mid-move
   always_ff @(posedge hclk) begin
      cnt       <= pulse_enable ? cnt + 8'h01 : 8'h00;
      move_done <= pulse_enable && cnt == move_len;
   end
endmodule

/* dv/sq_sequencer_tb.sv */
// Self-checking bench for the step sequencer: AHB-Lite register tasks plus program runs.
// Assumes sq_pkg, the design files and sq_partner are compiled first.
`timescale 1ns/10ps
module sq_sequencer_tb;
   import sq_pkg::*;
   localparam int TK = 8;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        servo_on, positive_side_input, negative_side_input, step_change_input, move_done;
   logic        swap, start_cmd, search_cmd, step_cmd;
   logic [7:0]  move_len;
   logic [15:0] motion_ref_in, motion_ref_out;
   logic        pulse_enable, program_done, homing_start, homing_dir_fwd;
   logic [3:0]  current_step;
   int          errors, checks_done, n;

   assign hready = hreadyout;

   sq_sequencer #(.TICK_CYCLES(TK)) dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .servo_on(servo_on), .positive_side_input(positive_side_input),
      .negative_side_input(negative_side_input), .step_change_input(step_change_input),
      .move_done(move_done), .motion_ref_in(motion_ref_in), .motion_ref_out(motion_ref_out),
      .pulse_enable(pulse_enable), .current_step(current_step), .program_done(program_done),
      .homing_start(homing_start), .homing_dir_fwd(homing_dir_fwd));

   sq_partner partner_u (
      .hclk(hclk), .swap(swap), .start_cmd(start_cmd), .search_cmd(search_cmd), .step_cmd(step_cmd),
      .pulse_enable(pulse_enable), .move_len(move_len), .positive_side_input(positive_side_input),
      .negative_side_input(negative_side_input), .step_change_input(step_change_input),
      .move_done(move_done));

   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   task automatic summarize();
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Single word transfer; read data taken at the edge closing the data phase
   task automatic bus(input logic wr_en, input logic [11:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {20'h00000, a};
      hwrite <= wr_en;
      hsize  <= 3'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      bus(1'b1, a, wd);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rd, exp);
   endtask

   // Cycles until pulse_enable reaches lvl; a hang counts as a mismatch
   task automatic wait_pe(input logic lvl);
      n = 0;
      while (pulse_enable !== lvl && n < 3000) begin
         @(posedge hclk);
         n++;
      end
      if (n >= 3000) begin
         errors++;
         $display("ERROR t=%0t pulse_enable wait timed out", $time);
      end
   endtask

   initial begin
      repeat (40000) @(posedge hclk);
      errors++;
      $display("ERROR t=%0t watchdog expired", $time);
      summarize();
   end

   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2;
      hwdata = 32'h0; servo_on = 1'b0; swap = 1'b0; start_cmd = 1'b0; search_cmd = 1'b0;
      step_cmd = 1'b0; move_len = 8'h14; motion_ref_in = 16'h1000; errors = 0; checks_done = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values, reserved and unmapped places, upper bits
      rd_chk(SQ_OFS_FILT + 12'h03C, 32'h0);
      rd_chk(SQ_OFS_DWELL + 12'h03C, 32'h0);
      rd_chk(SQ_OFS_CFG, 32'h0);
      rd_chk(SQ_OFS_STEPS, 32'h0000_0F00);
      rd_chk(SQ_OFS_STATUS, 32'h0000_0100);
      wr(SQ_OFS_RSVD, 32'hFFFF_FFFF);
      rd_chk(SQ_OFS_RSVD, 32'h0);
      rd_chk(12'h0A0, 32'h0);
      wr(SQ_OFS_DWELL + 12'h03C, 32'hABCD_0001);
      rd_chk(SQ_OFS_DWELL + 12'h03C, 32'h1);
      // Mode 2 single run over the last two steps, slow filter then none
      wr(SQ_OFS_FILT + 12'h038, 32'hF);
      wr(SQ_OFS_DWELL + 12'h038, 32'h3);
      wr(SQ_OFS_CFG, 32'h21);
      wr(SQ_OFS_STEPS, 32'h0F0E);
      servo_on <= 1'b1;
      repeat (40) @(posedge hclk);
      check(32'(pulse_enable), 32'h0);
      start_cmd <= 1'b1;
      wait_pe(1'b1);
      check(32'(current_step), 32'hE);
      repeat (10) @(posedge hclk);
      check(32'(motion_ref_out), 32'h0);
      wait_pe(1'b0);
      wait_pe(1'b1);
      check(32'(n > 2 * TK && n <= 3 * TK + 4), 32'h1);
      check(32'(current_step), 32'hF);
      repeat (8) @(posedge hclk);
      check(32'(motion_ref_out), 32'h1000);
      wait_pe(1'b0);
      for (n = 0; n < 200 && program_done !== 1'b1; n++) @(posedge hclk);
      check(32'(program_done), 32'h1);
      check(32'(pulse_enable), 32'h0);
      // Start released mid-move, then soft reset
      servo_on <= 1'b0;
      move_len <= 8'hC8;
      wr(SQ_OFS_STEPS, 32'h0605);
      servo_on <= 1'b1;
      wait_pe(1'b1);
      check(32'(current_step), 32'h5);
      start_cmd <= 1'b0;
      wait_pe(1'b0);
      check(32'(n <= 6), 32'h1);
      check(32'(current_step), 32'h5);
      wr(SQ_OFS_STEPS, 32'h0609);
      wr(SQ_OFS_CTRL, 32'h1);
      repeat (2) @(posedge hclk);
      check(32'(current_step), 32'h9);
      // Search input for every selection code
      servo_on <= 1'b0;
      for (int s = 0; s < 4; s++) begin
         wr(SQ_OFS_CFG, 32'(s));
         swap       <= s[1];
         search_cmd <= 1'b1;
         for (n = 0; n < 12 && homing_start !== 1'b1; n++) @(posedge hclk);
         check(32'(homing_start), 32'h1);
         check(32'(homing_dir_fwd), 32'h1);
         search_cmd <= 1'b0;
         repeat (4) @(posedge hclk);
      end
      swap <= 1'b0;
      // Mode 0 cyclic over steps 0 and 1, no start input
      move_len <= 8'h04;
      wr(SQ_OFS_CFG, 32'h0);
      wr(SQ_OFS_STEPS, 32'h0100);
      wr(SQ_OFS_DWELL, 32'h1);
      wr(SQ_OFS_DWELL + 12'h004, 32'h1);
      wr(SQ_OFS_DWELL + 12'h008, 32'h1);
      servo_on <= 1'b1;
      wait_pe(1'b1);
      check(32'(current_step), 32'h0);
      wait_pe(1'b0);
      wait_pe(1'b1);
      check(32'(current_step), 32'h1);
      wait_pe(1'b0);
      wait_pe(1'b1);
      check(32'(current_step), 32'h0);
      servo_on <= 1'b0;
      // Mode 1, edge detect then level detect of the step-change input
      wr(SQ_OFS_CFG, 32'h0110);
      wr(SQ_OFS_STEPS, 32'h0200);
      servo_on <= 1'b1;
      wait_pe(1'b1);
      check(32'(current_step), 32'h0);
      wait_pe(1'b0);
      repeat (100) @(posedge hclk);
      check(32'(pulse_enable), 32'h0);
      step_cmd <= 1'b1;
      wait_pe(1'b1);
      check(32'(current_step), 32'h1);
      wait_pe(1'b0);
      move_len <= 8'h28;
      repeat (100) @(posedge hclk);
      check(32'(current_step), 32'h1);
      wr(SQ_OFS_CFG, 32'h0010);
      wait_pe(1'b1);
      check(32'(current_step), 32'h2);
      step_cmd <= 1'b0;
      repeat (10) @(posedge hclk);
      check(32'(pulse_enable), 32'h1);
      // Mode 3 single run, start on the negative input, level step input
      servo_on  <= 1'b0;
      swap      <= 1'b1;
      start_cmd <= 1'b1;
      wr(SQ_OFS_CFG, 32'h0033);
      wr(SQ_OFS_STEPS, 32'h0100);
      servo_on <= 1'b1;
      wait_pe(1'b1);
      check(32'(current_step), 32'h0);
      wait_pe(1'b0);
      repeat (50) @(posedge hclk);
      check(32'(pulse_enable), 32'h0);
      step_cmd <= 1'b1;
      wait_pe(1'b1);
      check(32'(current_step), 32'h1);
      step_cmd  <= 1'b0;
      start_cmd <= 1'b0;
      wait_pe(1'b0);
      check(32'(n <= 6), 32'h1);
      summarize();
   end
endmodule
